//--- include/ipc_regs.vh
// register indices, field positions and reset values of the interrupt pin block
// assumes a 32-bit apb slave with each register in one aligned word (byte = 4 * index)
`ifndef IPC_REGS_VH
`define IPC_REGS_VH

// register indices; byte address is four times the index
`define IPC_IDX_CFG        8'h7d
`define IPC_IDX_STATUS     8'h80
`define IPC_IDX_MASK       8'h81
`define IPC_IDX_PIN        8'h82

// apb address width and word alignment
`define IPC_AW             12
`define IPC_DW             32
`define IPC_IDX_W          8

// pin configuration fields
`define IPC_CFG_W          3
`define IPC_CFG_POL        0
`define IPC_CFG_FLOAT      1
`define IPC_CFG_GPO        2
`define IPC_CFG_RESET      3'h2

// interrupt status and mask
`define IPC_EV_W           8
`define IPC_STATUS_RESET   8'h00
`define IPC_MASK_RESET     8'h00

// pin state readback fields
`define IPC_PIN_W          3
`define IPC_PIN_LEVEL      0
`define IPC_PIN_DRIVEN     1
`define IPC_PIN_ASSERTED   2

// synchroniser depth for the pin readback
`define IPC_SYNC_W         3

`endif

//--- verilog/ipc_pin_drv.v
// output stage of the interrupt request pin: level and enable from configuration
// assumes pending comes from logic on core_clk; pad resolves wire level from enable
`timescale 1ns/100ps

module ipc_pin_drv (
   input  wire core_clk,
   input  wire resetn,
   input  wire pending,
   input  wire gpo_sel,
   input  wire float_idle,
   input  wire polarity,
   output reg  pin_o,
   output reg  pin_oe,
   output reg  asserted_q
);

`include "ipc_regs.vh"

   reg asserted_d;
   reg level_d;
   reg drive_d;

   always @* begin
      // general output: no interrupt state, the polarity bit is the level
      if (gpo_sel) begin // see (R01)
         asserted_d = 1'b0;
         level_d    = polarity; // see (R02)
         drive_d    = 1'b1;
      end else begin
         asserted_d = pending; // see (R05)
         // active low when polarity is 0, active high when 1
         level_d    = pending ? polarity : ~polarity; // see (R04)
         // floating idle: drive only while asserted
         drive_d    = float_idle ? pending : 1'b1; // see (R03)
      end
   end

   always @(posedge core_clk) begin
      if (!resetn) begin
         pin_o      <= 1'b1;
         pin_oe     <= 1'b0;
         asserted_q <= 1'b0;
      end else begin
         pin_o      <= level_d;
         pin_oe     <= drive_d;
         asserted_q <= asserted_d;
      end
   end

endmodule // ipc_pin_drv

//--- verilog/ipc_top.v
// interrupt pin block: apb registers, sticky interrupt status, mask, pin output stage
// assumes events come from logic on core_clk; the pin readback comes from the pad
//
// How it works
// (R01) general-output select set: pin leaves interrupt duty, becomes general output
// (R02) in general-output use the pin shows the polarity bit's value
// (R03) float bit 0: always driven; 1: driven only while asserted, else released
// (R04) interrupt shown low with polarity 0, high with polarity 1
// (R05) pin asserted while any unmasked event is pending; released once software clears
//
// Local design decision: the APB register port.
`timescale 1ns/100ps

module ipc_top (
   input  wire        core_clk,
   input  wire        resetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output wire        pready,
   output reg  [31:0] prdata,
   output reg         pslverr,
   input  wire [7:0]  irq_event,
   output reg         irq_o,
   output wire        irq_pin_o,
   output wire        irq_pin_oe,
   input  wire        irq_pin_i
);

`include "ipc_regs.vh"

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------

   function hit;
      input [`IPC_AW-1:0]    addr;
      input [`IPC_IDX_W-1:0] idx;
      begin
         hit = (addr == {2'b00, idx, 2'b00});
      end
   endfunction

   function [`IPC_DW-1:0] zext_ev;
      input [`IPC_EV_W-1:0] v;
      begin
         zext_ev = {{(`IPC_DW-`IPC_EV_W){1'b0}}, v};
      end
   endfunction

   wire sel_cfg;
   wire sel_status;
   wire sel_mask;
   wire sel_pin;
   wire mapped;
   wire setup;
   wire access;
   wire wr_access;
   wire lane0;

   assign sel_cfg    = hit(paddr, `IPC_IDX_CFG);
   assign sel_status = hit(paddr, `IPC_IDX_STATUS);
   assign sel_mask   = hit(paddr, `IPC_IDX_MASK);
   assign sel_pin    = hit(paddr, `IPC_IDX_PIN);
   assign mapped     = sel_cfg | sel_status | sel_mask | sel_pin;

   // zero wait states: every access completes in its first access cycle
   assign pready     = 1'b1;
   assign setup      = psel & ~penable;
   assign access     = psel & penable;
   assign wr_access  = access & pwrite & mapped;
   assign lane0      = pstrb[0];

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------

   reg  [`IPC_CFG_W-1:0] cfg_q;
   reg  [`IPC_CFG_W-1:0] cfg_d;
   reg  [`IPC_EV_W-1:0]  status_q;
   reg  [`IPC_EV_W-1:0]  status_d;
   reg  [`IPC_EV_W-1:0]  mask_q;
   reg  [`IPC_EV_W-1:0]  mask_d;

   wire                  gpo_sel;
   wire                  float_idle;
   wire                  polarity;

   assign gpo_sel    = cfg_q[`IPC_CFG_GPO];
   assign float_idle = cfg_q[`IPC_CFG_FLOAT];
   assign polarity   = cfg_q[`IPC_CFG_POL];

   always @* begin
      cfg_d = cfg_q;
      if (wr_access && sel_cfg && lane0) begin
         cfg_d = pwdata[`IPC_CFG_W-1:0];
      end
   end

   always @* begin
      mask_d = mask_q;
      if (wr_access && sel_mask && lane0) begin
         mask_d = pwdata[`IPC_EV_W-1:0];
      end
   end

   // write one to clear; an event in the same cycle keeps its bit set
   always @* begin
      status_d = status_q;
      if (wr_access && sel_status && lane0) begin
         status_d = status_q & ~pwdata[`IPC_EV_W-1:0];
      end
      status_d = status_d | irq_event;
   end

   always @(posedge core_clk) begin
      if (!resetn) begin
         cfg_q    <= `IPC_CFG_RESET;
         mask_q   <= `IPC_MASK_RESET;
         status_q <= `IPC_STATUS_RESET;
      end else begin
         cfg_q    <= cfg_d;
         mask_q   <= mask_d;
         status_q <= status_d;
      end
   end

   // ------------------------------------------------------------------
   // interrupt level
   // ------------------------------------------------------------------

   wire pending_d;

   assign pending_d = |(status_q & mask_q); // see (R05)

   always @(posedge core_clk) begin
      if (!resetn) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= pending_d;
      end
   end

   // ------------------------------------------------------------------
   // pin output stage
   // ------------------------------------------------------------------

   wire pin_asserted;

   // pending level, mode, float and polarity select level and enable
   ipc_pin_drv u_pin_drv (
      .core_clk   (core_clk),
      .resetn     (resetn),
      .pending    (irq_o),      // see (R05)
      .gpo_sel    (gpo_sel),    // see (R01)
      .float_idle (float_idle), // see (R03)
      .polarity   (polarity),   // see (R04)
      .pin_o      (irq_pin_o),
      .pin_oe     (irq_pin_oe),
      .asserted_q (pin_asserted)
   );

   // ------------------------------------------------------------------
   // pin readback: three flops, level accepted when the last two agree
   // ------------------------------------------------------------------

   reg [`IPC_SYNC_W-1:0] pin_sync_q;
   reg                   pin_level_q;
   reg                   pin_level_d;

   always @(posedge core_clk) begin
      if (!resetn) begin
         pin_sync_q <= {`IPC_SYNC_W{1'b0}};
      end else begin
         pin_sync_q <= {pin_sync_q[`IPC_SYNC_W-2:0], irq_pin_i};
      end
   end

   always @* begin
      pin_level_d = pin_level_q;
      if (pin_sync_q[1] == pin_sync_q[2]) begin
         pin_level_d = pin_sync_q[2];
      end
   end

   always @(posedge core_clk) begin
      if (!resetn) begin
         pin_level_q <= 1'b0;
      end else begin
         pin_level_q <= pin_level_d;
      end
   end

   wire [`IPC_PIN_W-1:0] pin_state;

   assign pin_state[`IPC_PIN_LEVEL]    = pin_level_q;
   assign pin_state[`IPC_PIN_DRIVEN]   = irq_pin_oe;
   assign pin_state[`IPC_PIN_ASSERTED] = pin_asserted;

   // ------------------------------------------------------------------
   // read data and error, captured in the setup cycle
   // ------------------------------------------------------------------

   reg [`IPC_DW-1:0] rdata_d;

   always @* begin
      rdata_d = {`IPC_DW{1'b0}};
      if (sel_cfg) begin
         rdata_d = {{(`IPC_DW-`IPC_CFG_W){1'b0}}, cfg_q};
      end else if (sel_status) begin
         rdata_d = zext_ev(status_q);
      end else if (sel_mask) begin
         rdata_d = zext_ev(mask_q);
      end else if (sel_pin) begin
         rdata_d = {{(`IPC_DW-`IPC_PIN_W){1'b0}}, pin_state};
      end
   end

   always @(posedge core_clk) begin
      if (!resetn) begin
         prdata  <= {`IPC_DW{1'b0}};
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= pwrite ? {`IPC_DW{1'b0}} : rdata_d;
         pslverr <= ~mapped;
      end else if (access) begin
         prdata  <= prdata;
         pslverr <= pslverr;
      end else begin
         prdata  <= {`IPC_DW{1'b0}};
         pslverr <= 1'b0;
      end
   end

endmodule // ipc_top

//--- verification/ipc_host_pin.sv
// host side of the interrupt line: pulled-up wire input of the host processor
// assumes the block drives pin level and enable; line is shared and pulled high
`timescale 1ns/100ps

module ipc_host_pin (
   input  wire logic pin_o,
   input  wire logic pin_oe,
   output wire logic pin_i,
   output wire logic line
);
   // released line rises through the pull-up
   assign line  = pin_oe ? pin_o : 1'b1;
   assign pin_i = line;
endmodule // ipc_host_pin

//--- verification/ipc_chk_asserts.sv
// assertions on the interrupt pin block ports
// assumes the register offsets of ipc_regs.vh; bound to ipc_top
`timescale 1ns/100ps
`include "ipc_regs.vh"

module ipc_chk (
   input wire logic        core_clk,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [7:0]  irq_event,
   input wire logic        irq_o,
   input wire logic        irq_pin_o,
   input wire logic        irq_pin_oe
);
   logic [2:0] cfg_q;
   wire        wr = psel && penable && pwrite;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // shadow of the pin configuration register
   always @(posedge core_clk)
      if (!resetn) cfg_q <= `IPC_CFG_RESET;
      else if (wr && pstrb[0] && paddr == {2'h0, `IPC_IDX_CFG, 2'h0}) cfg_q <= pwdata[2:0];
   property p_gpo; $past(cfg_q[2]) |-> irq_pin_oe && irq_pin_o == $past(cfg_q[0]); endproperty
   a_gpo: assert property (p_gpo) else $error("general output level wrong");
   property p_act; !$past(cfg_q[2]) && $past(irq_o) |-> irq_pin_oe && irq_pin_o == $past(cfg_q[0]);
   endproperty
   a_act: assert property (p_act) else $error("asserted pin level wrong");
   property p_idle; !$past(cfg_q[2]) && !$past(irq_o) |->
      irq_pin_oe == !$past(cfg_q[1]) && (!irq_pin_oe || irq_pin_o == !$past(cfg_q[0])); endproperty
   a_idle: assert property (p_idle) else $error("idle pin drive wrong");
   property p_rise; $rose(irq_o) |-> $past(irq_event, 2) != 8'h00 || $past(wr, 2); endproperty
   a_rise: assert property (p_rise) else $error("interrupt rose without cause");
   property p_fall; $fell(irq_o) |-> $past(wr, 2); endproperty
   a_fall: assert property (p_fall) else $error("interrupt fell without write");
   // a clear lands one edge before irq_o can fall, so the write before also counts
   property p_hold; irq_o && !wr && !$past(wr) |=> irq_o; endproperty
   a_hold: assert property (p_hold) else $error("interrupt dropped while pending");
endmodule // ipc_chk

bind ipc_top ipc_chk chk_u (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pstrb, .irq_event, .irq_o, .irq_pin_o, .irq_pin_oe);

//--- verification/ipc_tb_top.sv
// self-checking bench of the interrupt pin block
// assumes ipc_top with apb registers and a pulled-up host line model
`timescale 1ns/100ps
`include "ipc_regs.vh"

module ipc_tb_top;
   localparam [11:0] a_cfg = {2'h0, `IPC_IDX_CFG, 2'h0};
   localparam [11:0] a_st  = {2'h0, `IPC_IDX_STATUS, 2'h0};
   localparam [11:0] a_mk  = {2'h0, `IPC_IDX_MASK, 2'h0};
   localparam [11:0] a_pin = {2'h0, `IPC_IDX_PIN, 2'h0};
   logic        core_clk, resetn, psel, penable, pwrite, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   logic [3:0]  pstrb;
   logic [7:0]  irq_event;
   wire         pready, pslverr, irq_o, irq_pin_o, irq_pin_oe, irq_pin_i;
   wire  [31:0] prdata;
   int          bad_count, compares;

   ipc_top dut_u (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .irq_event(irq_event), .irq_o(irq_o),
      .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe), .irq_pin_i(irq_pin_i));
   ipc_host_pin host_u (.pin_o(irq_pin_o), .pin_oe(irq_pin_oe), .pin_i(irq_pin_i), .line());

   initial begin
      core_clk = 0;
      forever #20 core_clk = ~core_clk;
   end

   task cmp(input [31:0] got, input [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask

   task apb(input w, input [11:0] a, input [31:0] d);
      @(posedge core_clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      forever begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task pulse(input [7:0] e);
      @(posedge core_clk);
      irq_event <= e;
      @(posedge core_clk);
      irq_event <= 8'h00;
      repeat (3) @(posedge core_clk);
   endtask

   task t_reset;
      apb(0, a_cfg, 0); cmp(rd, 32'h2);
      apb(0, a_pin, 0); cmp(rd, 32'h1);
      apb(1, 12'h010, 32'hff); cmp(err, 1);
      apb(0, a_cfg, 0); cmp(rd, 32'h2);
   endtask

   task t_float;
      apb(1, a_mk, 32'h1);
      pulse(8'h01); cmp({irq_o, irq_pin_oe, irq_pin_o}, 3'b110);
      apb(1, a_st, 32'h1); repeat (3) @(posedge core_clk);
      cmp({irq_o, irq_pin_oe, irq_pin_i}, 3'b001);
   endtask

   task t_driven;
      apb(1, a_cfg, 32'h1); repeat (2) @(posedge core_clk);
      cmp({irq_o, irq_pin_oe, irq_pin_o}, 3'b010);
      pulse(8'h08); cmp({irq_o, irq_pin_oe, irq_pin_o}, 3'b010);
      apb(1, a_mk, 32'h8); repeat (3) @(posedge core_clk);
      cmp({irq_o, irq_pin_oe, irq_pin_o}, 3'b111);
      apb(1, a_st, 32'h8); repeat (3) @(posedge core_clk);
      cmp({irq_o, irq_pin_oe, irq_pin_o}, 3'b010);
   endtask

   task t_gpo;
      apb(1, a_cfg, 32'h4); repeat (2) @(posedge core_clk);
      cmp({irq_pin_oe, irq_pin_o}, 2'b10);
      pulse(8'h08); cmp({irq_o, irq_pin_oe, irq_pin_o}, 3'b110);
      apb(1, a_cfg, 32'h7); repeat (2) @(posedge core_clk);
      cmp({irq_pin_oe, irq_pin_o}, 2'b11);
   endtask

   task stop_test;
      if (bad_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      pstrb = 4'hf; irq_event = 8'h00; bad_count = 0; compares = 0;
      repeat (4) @(posedge core_clk);
      resetn <= 1;
      t_reset;
      t_float;
      t_driven;
      t_gpo;
      stop_test;
   end

   initial begin
      repeat (2000) @(posedge core_clk);
      bad_count++;
      stop_test;
   end
endmodule // ipc_tb_top
